// ### stx_pkg.sv
// Shared constants for the parity-capable serial transmitter
package stx_pkg;
    // ==========================================
    // Character size codes and widths
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [3:0] DATA_BITS_MIN = 4'h5;
    localparam logic [3:0] DATA_BITS_NINE = 4'h9;
    localparam int FRAME_W = 13;
    // ==========================================
    // Bit timing in baud ticks
    localparam logic [4:0] TICKS_NORMAL = 5'h10;
    localparam logic [4:0] TICKS_DOUBLE = 5'h08;
    // ==========================================
    // Reset values and line levels
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LVL = 1'b0;
    localparam logic PARITY_EVEN_SEED = 1'b0;
    localparam logic PARITY_ODD_SEED = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PEND = 2'b01,
        ST_SEND = 2'b10
    } stx_state_t;
endpackage

// ### stx_clk_if.sv
// Bit-period timing signals between timer and transmitter
`timescale 1ns/100ps
interface stx_clk_if;
    logic doubleSpeed;
    logic syncMode;
    logic clockPolarity;
    logic bitTick;
    modport gen (input doubleSpeed, input syncMode, input clockPolarity, output bitTick);
    modport use_m (output doubleSpeed, output syncMode, output clockPolarity, input bitTick);
endinterface

// ### stx_bit_timer.sv
// Bit period timer: baud tick divider or synchronous clock edge
`timescale 1ns/100ps
module stx_bit_timer
    import stx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Timing sources
    input wire logic baudTick,
    input wire logic syncClockPin,
    // Timing carrier
    stx_clk_if.gen tif
);
    logic [4:0] divCnt_ff;
    logic [2:0] pinSync_ff;
    logic pinLevel_ff;
    logic tick_ff;
    logic pinSettled;
    logic pinEdge;
    logic [4:0] divEnd;

    assign divEnd = tif.doubleSpeed ? TICKS_DOUBLE : TICKS_NORMAL;
    // Change counts once stages two and three agree
    assign pinSettled = (pinSync_ff[1] == pinSync_ff[2]);
    assign pinEdge = pinSettled && (pinSync_ff[2] != pinLevel_ff);

    // ==========================================
    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinSync_ff <= 3'h0;
            pinLevel_ff <= 1'b0;
        end else begin
            pinSync_ff <= {pinSync_ff[1:0], syncClockPin};
            if (pinSettled) begin
                pinLevel_ff <= pinSync_ff[2];
            end
        end
    end

    // ==========================================
    // Baud tick divider
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            divCnt_ff <= 5'h00;
        end else if (tif.syncMode) begin
            divCnt_ff <= 5'h00;
        end else if (baudTick) begin
            divCnt_ff <= (divCnt_ff + 5'h01 >= divEnd) ? 5'h00 : divCnt_ff + 5'h01;
        end
    end

    // ==========================================
    // One-cycle bit tick
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_ff <= 1'b0;
        end else if (tif.syncMode) begin
            // Data changes on rising edge, or falling with polarity set
            tick_ff <= pinEdge && (pinSync_ff[2] != tif.clockPolarity);
        end else begin
            tick_ff <= baudTick && (divCnt_ff + 5'h01 >= divEnd);
        end
    end

    assign tif.bitTick = tick_ff;
endmodule

// ### stx_transmitter.sv
// Transmit half of a serial port with one-deep buffer and parity
// Notes on behaviour
// - Parity is XOR of data bits, inverted for odd parity.
// - Parity bit sits after last data bit, before first stop bit.
// - While enabled, the transmitter drives the transmit data pin.
// - Synchronous mode times bits from the external clock pin.
// - A data write loads the buffer and starts a transmission.
// - Buffer moves to shifter when idle or right after last stop bit.
// - Shifter sends a whole frame at the selected bit rate.
// - Unused high data bits are ignored for short characters.
// - Ninth bit is written first and sent as data MSB.
// - Buffer-empty flag set while buffer is empty, else clear.
// - Writing data clears the buffer-empty flag.
// - Buffer-empty interrupt requested while flag, enable and global enable set.
// - Transmit-complete set when frame done and buffer empty.
// - Transmit-complete clears on interrupt service or software write of one.
// - Transmit-complete interrupt requested when flag set and enabled.
// - Frame opens with start bit, data LSB first; idle line high.
// - Parity bit only inserted when parity upper mode bit is one.
// - Disable waits for shifter and buffer to empty, then releases pin.
`timescale 1ns/100ps
module stx_transmitter
    import stx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Processor writes
    input wire logic dataWrite,
    input wire logic [7:0] serialDataIn,
    input wire logic txNinthBit,
    input wire logic txCompleteClearWrite,
    input wire logic txCompleteIrqAck,
    // Configuration
    input wire logic txEnableBit,
    input wire logic [2:0] charSizeField,
    input wire logic parityModeUpperBit,
    input wire logic parityModeLowerBit,
    input wire logic stopBitSelect,
    input wire logic doubleSpeedBit,
    input wire logic syncMode,
    input wire logic clockPolarity,
    input wire logic bufferEmptyIrqEnable,
    input wire logic txCompleteIrqEnable,
    input wire logic globalIrqEnable,
    // Timing sources
    input wire logic baudTick,
    input wire logic syncClockPin,
    // Serial line
    output logic txData,
    output logic txDataOe,
    // Status and interrupts
    output logic bufferEmptyFlag,
    output logic txCompleteFlag,
    output logic bufferEmptyIrq,
    output logic txCompleteIrq
);
    stx_state_t state_ff;
    logic [8:0] bufData_ff;
    logic bufFull_ff;
    logic [FRAME_W-1:0] shift_ff;
    logic [3:0] bitsLeft_ff;
    logic txData_ff;
    logic pinOwned_ff;
    logic bufEmpty_ff;
    logic txc_ff;
    logic bufIrq_ff;
    logic txcIrq_ff;
    logic bitTick;
    logic lastDone;
    logic moveBuf;
    logic txcSet;
    logic [FRAME_W-1:0] newFrame;

    stx_clk_if tif ();
    assign tif.doubleSpeed = doubleSpeedBit;
    assign tif.syncMode = syncMode;
    assign tif.clockPolarity = clockPolarity;
    assign bitTick = tif.bitTick;

    stx_bit_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .baudTick(baudTick),
        .syncClockPin(syncClockPin),
        .tif(tif)
    );

    // ==========================================
    // Frame decoding helpers
    function automatic logic [3:0] dataBits(input logic [2:0] csz);
        if (csz == CSZ_NINE) begin
            dataBits = DATA_BITS_NINE;
        end else begin
            dataBits = DATA_BITS_MIN + {2'b00, csz[1:0]};
        end
    endfunction

    function automatic logic [3:0] frameLen(input logic [2:0] csz, input logic par, input logic two);
        frameLen = 4'h1 + dataBits(csz) + {3'h0, par} + {3'h0, two} + 4'h1;
    endfunction

    function automatic logic [FRAME_W-1:0] buildFrame(
        input logic [8:0] d, input logic [2:0] csz, input logic par, input logic odd
    );
        logic [3:0] n;
        logic p;
        n = dataBits(csz);
        p = odd ? PARITY_ODD_SEED : PARITY_EVEN_SEED;
        buildFrame = {FRAME_W{LINE_IDLE}};
        buildFrame[0] = START_LVL;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                buildFrame[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (par) begin
            buildFrame[n+4'h1] = p;
        end
    endfunction

    assign newFrame = buildFrame(bufData_ff, charSizeField, parityModeUpperBit, parityModeLowerBit);
    assign lastDone = (state_ff == ST_SEND) && bitTick && (bitsLeft_ff == 4'h0);
    // Transfer when idle, or straight after the last stop bit
    assign moveBuf = bufFull_ff && pinOwned_ff && ((state_ff == ST_IDLE) || lastDone);
    assign txcSet = lastDone && !bufFull_ff;

    // ==========================================
    // Transmit buffer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bufData_ff <= 9'h000;
            bufFull_ff <= 1'b0;
        end else if (dataWrite) begin
            // Ninth bit sampled with the low byte, so it must be set first
            bufData_ff <= {txNinthBit, serialDataIn};
            bufFull_ff <= 1'b1;
        end else if (moveBuf) begin
            bufFull_ff <= 1'b0;
        end
    end

    // ==========================================
    // Shifter and line
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            shift_ff <= {FRAME_W{LINE_IDLE}};
            bitsLeft_ff <= 4'h0;
            txData_ff <= LINE_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (moveBuf) begin
                        shift_ff <= newFrame;
                        bitsLeft_ff <= frameLen(charSizeField, parityModeUpperBit, stopBitSelect);
                        state_ff <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    if (bitTick) begin
                        txData_ff <= shift_ff[0];
                        shift_ff <= {LINE_IDLE, shift_ff[FRAME_W-1:1]};
                        bitsLeft_ff <= bitsLeft_ff - 4'h1;
                        state_ff <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (bitTick) begin
                        if (bitsLeft_ff != 4'h0) begin
                            txData_ff <= shift_ff[0];
                            shift_ff <= {LINE_IDLE, shift_ff[FRAME_W-1:1]};
                            bitsLeft_ff <= bitsLeft_ff - 4'h1;
                        end else if (moveBuf) begin
                            // Back-to-back frame: start bit follows last stop bit
                            txData_ff <= START_LVL;
                            shift_ff <= {LINE_IDLE, newFrame[FRAME_W-1:1]};
                            bitsLeft_ff <= frameLen(charSizeField, parityModeUpperBit, stopBitSelect) - 4'h1;
                        end else begin
                            txData_ff <= LINE_IDLE;
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Pin ownership; disable waits for an empty transmitter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinOwned_ff <= 1'b0;
        end else if (txEnableBit) begin
            pinOwned_ff <= 1'b1;
        end else if ((state_ff == ST_IDLE) && !bufFull_ff) begin
            pinOwned_ff <= 1'b0;
        end
    end

    // ==========================================
    // Flags; a write beats a simultaneous buffer move, a complete set beats a simultaneous clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bufEmpty_ff <= 1'b1;
            txc_ff <= 1'b0;
        end else begin
            if (dataWrite) begin
                bufEmpty_ff <= 1'b0;
            end else if (moveBuf) begin
                bufEmpty_ff <= 1'b1;
            end
            if (txcSet) begin
                txc_ff <= 1'b1;
            end else if (txCompleteClearWrite || txCompleteIrqAck) begin
                txc_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Interrupt requests
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bufIrq_ff <= 1'b0;
            txcIrq_ff <= 1'b0;
        end else begin
            bufIrq_ff <= bufEmpty_ff && bufferEmptyIrqEnable && globalIrqEnable;
            txcIrq_ff <= txc_ff && !txCompleteIrqAck && txCompleteIrqEnable && globalIrqEnable;
        end
    end

    assign txData = txData_ff;
    assign txDataOe = pinOwned_ff;
    assign bufferEmptyFlag = bufEmpty_ff;
    assign txCompleteFlag = txc_ff;
    assign bufferEmptyIrq = bufIrq_ff;
    assign txCompleteIrq = txcIrq_ff;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_lastStop;
        (state_ff == ST_SEND) && bitTick && (bitsLeft_ff == 4'h0);
    endsequence
    sequence s_noWaiting;
        !bufFull_ff;
    endsequence

    property p_writeClears;
        dataWrite |=> !bufEmpty_ff;
    endproperty
    a_writeClears: assert property (p_writeClears) else $error("Write left buffer empty");

    property p_fullNotEmpty;
        bufFull_ff |-> !bufEmpty_ff;
    endproperty
    a_fullNotEmpty: assert property (p_fullNotEmpty) else $error("Empty flag with full buffer");

    property p_bufIrq;
        bufEmpty_ff && bufferEmptyIrqEnable && globalIrqEnable |=> bufIrq_ff;
    endproperty
    a_bufIrq: assert property (p_bufIrq) else $error("Buffer empty irq missing");

    property p_txcIrq;
        $rose(txc_ff) && txCompleteIrqEnable && globalIrqEnable |=> txcIrq_ff;
    endproperty
    a_txcIrq: assert property (p_txcIrq) else $error("Complete irq missing");

    property p_txcClear;
        (txCompleteClearWrite || txCompleteIrqAck) && !txcSet |=> !txc_ff;
    endproperty
    a_txcClear: assert property (p_txcClear) else $error("Complete flag not cleared");

    property p_txcSet;
        s_lastStop ##0 s_noWaiting |=> txc_ff && (state_ff == ST_IDLE);
    endproperty
    a_txcSet: assert property (p_txcSet) else $error("Complete flag not set");

    property p_idleHigh;
        (state_ff == ST_IDLE) |-> txData_ff == LINE_IDLE;
    endproperty
    a_idleHigh: assert property (p_idleHigh) else $error("Line not idle high");

    property p_enableDrives;
        txEnableBit |=> txDataOe;
    endproperty
    a_enableDrives: assert property (p_enableDrives) else $error("Pin not driven");

    property p_disableRelease;
        !txEnableBit && (state_ff == ST_IDLE) && !bufFull_ff |=> !txDataOe;
    endproperty
    a_disableRelease: assert property (p_disableRelease) else $error("Pin not released");

    property p_startBit;
        (state_ff == ST_PEND) && bitTick |=> txData_ff == START_LVL;
    endproperty
    a_startBit: assert property (p_startBit) else $error("Start bit missing");
endmodule

// ### stx_rx_model.sv
// Remote serial receiver model sampling the transmit line at bit centres
`timescale 1ns/100ps
module stx_rx_model (
    // Clock
    input wire logic clk,
    // Line and frame format
    input wire logic line,
    input wire logic [7:0] bitCycles,
    input wire logic [3:0] nData,
    input wire logic parEn,
    input wire logic twoStop,
    // Received frame
    output logic [8:0] rxData,
    output logic rxPar,
    output logic rxStopOk,
    output logic [7:0] rxCount
);
    initial begin
        rxData = 9'h000;
        rxPar = 1'b0;
        rxStopOk = 1'b0;
        rxCount = 8'h00;
        forever begin
            // ==========================================
            // Start edge, then centre of each bit
            @(posedge clk iff line === 1'b0);
            repeat (bitCycles / 2) @(posedge clk);
            // A short low pulse is noise, not a start bit
            if (line === 1'b0) begin
                rxData = 9'h000;
                for (int i = 0; i < nData; i++) begin
                    repeat (bitCycles) @(posedge clk);
                    rxData[i] = line;
                end
                if (parEn) begin
                    repeat (bitCycles) @(posedge clk);
                    rxPar = line;
                end
                rxStopOk = 1'b1;
                for (int i = 0; i < (twoStop ? 2 : 1); i++) begin
                    repeat (bitCycles) @(posedge clk);
                    rxStopOk = rxStopOk & line;
                end
                rxCount = rxCount + 8'h01;
            end
        end
    end
endmodule

// ### serial_transmitter_parity_tb_top.sv
// Self-checking bench for the parity-capable serial transmitter
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
        errCount++; \
        $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module serial_transmitter_parity_tb_top;
    import stx_pkg::*;
    logic clk, rst_b, dataWrite, txNinthBit, txCompleteClearWrite, txCompleteIrqAck, txEnableBit;
    logic [7:0] serialDataIn;
    logic [2:0] charSizeField;
    logic parityModeUpperBit, parityModeLowerBit, stopBitSelect, doubleSpeedBit;
    logic syncMode, clockPolarity;
    logic syncClockPin = 1'b0;
    logic baudTick = 1'b0;
    logic syncRun = 1'b0;
    int syncDiv = 0;
    logic bufferEmptyIrqEnable, txCompleteIrqEnable, globalIrqEnable;
    logic txData, txDataOe, bufferEmptyFlag, txCompleteFlag, bufferEmptyIrq, txCompleteIrq;
    logic [7:0] bitCyc, rxCount, old;
    logic [3:0] nData;
    logic [8:0] rxData;
    logic rxPar, rxStopOk;
    int errCount = 0;
    int numChecks = 0;
    int cycles = 0;

    stx_transmitter i_stx_transmitter (.clk(clk), .rst_b(rst_b), .dataWrite(dataWrite),
        .serialDataIn(serialDataIn), .txNinthBit(txNinthBit), .txCompleteClearWrite(txCompleteClearWrite),
        .txCompleteIrqAck(txCompleteIrqAck), .txEnableBit(txEnableBit), .charSizeField(charSizeField),
        .parityModeUpperBit(parityModeUpperBit), .parityModeLowerBit(parityModeLowerBit),
        .stopBitSelect(stopBitSelect), .doubleSpeedBit(doubleSpeedBit), .syncMode(syncMode),
        .clockPolarity(clockPolarity), .bufferEmptyIrqEnable(bufferEmptyIrqEnable),
        .txCompleteIrqEnable(txCompleteIrqEnable), .globalIrqEnable(globalIrqEnable), .baudTick(baudTick),
        .syncClockPin(syncClockPin), .txData(txData), .txDataOe(txDataOe), .bufferEmptyFlag(bufferEmptyFlag),
        .txCompleteFlag(txCompleteFlag), .bufferEmptyIrq(bufferEmptyIrq), .txCompleteIrq(txCompleteIrq));

    // Released line floats to the pull-up level
    stx_rx_model i_stx_rx_model (.clk(clk), .line(txDataOe ? txData : 1'b1), .bitCycles(bitCyc), .nData(nData),
        .parEn(parityModeUpperBit), .twoStop(stopBitSelect), .rxData(rxData), .rxPar(rxPar),
        .rxStopOk(rxStopOk), .rxCount(rxCount));

    // ==========================================
    // Clock, baud tick every second cycle, timeout
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) baudTick <= ~baudTick;
    // Slave clock of 16 cycles, stopped outside the synchronous tests
    always @(negedge clk) begin
        if (syncRun) begin
            syncDiv <= (syncDiv == 7) ? 0 : syncDiv + 1;
            if (syncDiv == 7) begin
                syncClockPin <= ~syncClockPin;
            end
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    // ==========================================
    // Access tasks, entered at a falling edge except conclude on timeout
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic sendChar(input logic [8:0] data);
        txNinthBit = data[8];
        serialDataIn = data[7:0];
        dataWrite = 1'b1;
        @(negedge clk);
        dataWrite = 1'b0;
    endtask
    task automatic pulseClear();
        txCompleteClearWrite = 1'b1;
        @(negedge clk);
        txCompleteClearWrite = 1'b0;
    endtask
    task automatic waitRx(input logic [7:0] prev);
        for (int i = 0; i < 1000 && rxCount === prev; i++) @(negedge clk);
        `CHK(rxCount, prev + 8'h01)
    endtask
    task automatic waitTxc();
        for (int i = 0; i < 1000 && txCompleteFlag !== 1'b1; i++) @(negedge clk);
        `CHK(txCompleteFlag, 1'b1)
    endtask
    // Format changes only while the line is idle
    task automatic setCfg(input logic [2:0] csz, input logic par, input logic odd, input logic two,
        input logic dbl);
        charSizeField = csz;
        parityModeUpperBit = par;
        parityModeLowerBit = odd;
        stopBitSelect = two;
        doubleSpeedBit = dbl;
        nData = (csz == CSZ_NINE) ? DATA_BITS_NINE : DATA_BITS_MIN + {2'b00, csz[1:0]};
        bitCyc = (syncMode || dbl) ? 8'h10 : 8'h20;
    endtask
    task automatic runFrame(input logic [2:0] csz, input logic par, input logic odd, input logic two,
        input logic dbl, input logic [8:0] data);
        logic [8:0] expData;
        setCfg(csz, par, odd, two, dbl);
        expData = data & (9'h1FF >> (4'h9 - nData));
        pulseClear();
        `CHK(txCompleteFlag, 1'b0)
        old = rxCount;
        sendChar(data);
        waitRx(old);
        `CHK(rxData, expData)
        if (par) `CHK(rxPar, ^expData ^ odd)
        `CHK(rxStopOk, 1'b1)
        waitTxc();
    endtask

    // ==========================================
    // Test sequence
    initial begin
        rst_b = 1'b0;
        {dataWrite, txNinthBit, txCompleteClearWrite, txCompleteIrqAck, txEnableBit} = 5'h00;
        {syncMode, clockPolarity} = 2'h0;
        {bufferEmptyIrqEnable, txCompleteIrqEnable, globalIrqEnable} = 3'h0;
        serialDataIn = 8'h00;
        setCfg(3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        `CHK({txData, txDataOe, bufferEmptyFlag, txCompleteFlag}, 4'hA)
        txEnableBit = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({txDataOe, txData}, 2'h3)
        $display("Test reset and enable done");

        runFrame(3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 9'h0A5);
        runFrame(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 9'h17F);
        runFrame(3'h0, 1'b1, 1'b1, 1'b1, 1'b0, 9'h013);
        runFrame(CSZ_NINE, 1'b1, 1'b0, 1'b0, 1'b0, 9'h13C);
        runFrame(3'h1, 1'b1, 1'b1, 1'b1, 1'b1, 9'h0E7);
        syncMode = 1'b1;
        syncRun = 1'b1;
        runFrame(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 9'h05A);
        clockPolarity = 1'b1;
        runFrame(3'h3, 1'b1, 1'b1, 1'b1, 1'b0, 9'h0C6);
        syncRun = 1'b0;
        {syncMode, clockPolarity} = 2'h0;
        $display("Test frame formats done");

        setCfg(3'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        pulseClear();
        old = rxCount;
        sendChar(9'h055);
        `CHK(bufferEmptyFlag, 1'b0)
        repeat (2) @(negedge clk);
        `CHK(bufferEmptyFlag, 1'b1)
        sendChar(9'h0A3);
        `CHK(bufferEmptyFlag, 1'b0)
        waitRx(old);
        `CHK({rxData, rxStopOk, bufferEmptyFlag, txCompleteFlag}, {9'h055, 3'h4})
        waitRx(old + 8'h01);
        `CHK(rxData, 9'h0A3)
        waitTxc();
        $display("Test back to back done");

        {bufferEmptyIrqEnable, txCompleteIrqEnable} = 2'h3;
        repeat (3) @(negedge clk);
        `CHK({bufferEmptyIrq, txCompleteIrq}, 2'h0)
        globalIrqEnable = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({bufferEmptyIrq, txCompleteIrq}, 2'h3)
        txCompleteIrqAck = 1'b1;
        @(negedge clk);
        txCompleteIrqAck = 1'b0;
        @(negedge clk);
        `CHK({txCompleteFlag, txCompleteIrq, bufferEmptyIrq}, 3'h1)
        bufferEmptyIrqEnable = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(bufferEmptyIrq, 1'b0)
        $display("Test interrupts done");

        old = rxCount;
        sendChar(9'h0C3);
        txEnableBit = 1'b0;
        repeat (40) @(negedge clk);
        `CHK(txDataOe, 1'b1)
        waitRx(old);
        `CHK(rxData, 9'h0C3)
        waitTxc();
        repeat (3) @(negedge clk);
        `CHK(txDataOe, 1'b0)
        $display("Test disable done");
        conclude();
    end
endmodule
